// File: ssp_defines.svh
// Register offsets, field positions, reset values and mode codes of the serial port.
// Included by the package file and the testbench; holds definitions only.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_OFS_BUFFER 8'h13
`define SSP_OFS_CONTROL 8'h14
`define SSP_OFS_STATUS 8'h94
`define SSP_OFS_ADDRESS 8'h93
`define SSP_BIT_WRITE_COLLISION_FLAG 7
`define SSP_BIT_OVF 6
`define SSP_BIT_EN 5
`define SSP_BIT_CKP 4
`define SSP_BIT_SMP 7
`define SSP_BIT_CKE 6
`define SSP_BIT_STOP 4
`define SSP_BIT_START 3
`define SSP_BIT_BF 0
`define SSP_CTRL_RESET 8'h00
`define SSP_STAT_RESET 8'h00
`define SSP_MODE_M4 4'h0
`define SSP_MODE_M16 4'h1
`define SSP_MODE_M64 4'h2
`define SSP_MODE_MT2 4'h3
`define SSP_MODE_SSS 4'h4
`define SSP_MODE_SNS 4'h5
`define SSP_MODE_I7 4'h6
`define SSP_MODE_I10 4'h7
`define SSP_MODE_IFM 4'hB
`define SSP_MODE_I7SP 4'hE
`define SSP_MODE_I10SP 4'hF
`define SSP_DIV_4 8'h01
`define SSP_DIV_16 8'h07
`define SSP_DIV_64 8'h1F
`define SSP_BITS 4'h8
`endif

// File: ssp_pkg.sv
// Types shared by the serial port design.
// Assumes ssp_defines.svh is on the include path.
`include "ssp_defines.svh"
package ssp_pkg;
	typedef enum logic [2:0] {
		SSP_IDLE = 3'b001,
		SSP_LEAD = 3'b010,
		SSP_TRAIL = 3'b100
	} ssp_state_type;
	typedef struct packed {
		logic clk;
		logic data;
	} ssp_pin_type;
endpackage : ssp_pkg

// File: ssp_port.sv
// Synchronous serial port: SPI master and slave, I2C pin control and start/stop flags.
// Assumes one 100 MHz clock, a synchronous active-low reset and a CPU register port.
// Overview of operation
// RULE_01: Buffer write during shift sets collision bit 7.
// RULE_02: Slave byte with full buffer sets overflow, dropped.
// RULE_03: Master never sets the overflow flag.
// RULE_04: I2C byte into full buffer sets overflow; the code receives no I2C bytes and never sets it.
// RULE_05: Enable bit 5 gives pins to port.
// RULE_06: SPI polarity bit 4 sets clock idle.
// RULE_07: I2C bit 4 zero stretches clock low.
// RULE_08: Mode 0-3 picks master clock divider.
// RULE_09: Mode 4 uses select, mode 5 ignores it.
// RULE_10: I2C mode codes six, seven, B, E, F.
// RULE_11: Eight bits shift out and in together.
// RULE_12: Software disables, reconfigures, re-enables to reset.
// RULE_13: Mode 4 resets shifting while select high.
// RULE_14: Software uses mode 4 when edge select set.
// RULE_15: Software sets pin directions correctly.
// RULE_16: I2C flags start and stop conditions.
// RULE_17: I2C pins driven open-drain when enabled.
// RULE_18: Shift register reachable only through buffer.
// RULE_19: Control and status reset to zero.
// RULE_20: Edge select picks the output clock edge; the master ignores it and always changes data on the return to idle.
// RULE_21: Sample phase picks middle or end sampling; in mode 0 the master always samples at the end.
// RULE_22: Buffer-full bit shows unread received byte.
// RULE_23: Reserved modes leave pins inactive.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ssp_port
	import ssp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic timer_two_in,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_out,
	input wire logic serial_data_in_pin_in,
	output logic serial_data_out_pin_out,
	output logic serial_data_out_pin_oe_out,
	output logic sda_oe_out,
	input wire logic slave_select_n_in
);
	logic [7:0] serial_port_control, next_control;
	logic [7:0] serial_port_status, next_status;
	logic [7:0] serial_buffer, next_buffer;
	logic [7:0] slave_address_register, next_address;
	logic [7:0] shift_register, next_shift;
	logic [3:0] bit_count, next_count;
	logic [7:0] div_count, next_div;
	logic [7:0] rdata, next_rdata;
	ssp_state_type state, next_state;
	logic sclk, next_sclk, serial_data_out_pin, next_sdo, t2_last, next_t2_last;
	ssp_pin_type pin_a, pin_b;
	logic ss_a, ss_b, t2_a, t2_b, sin_last, next_sin_last, sck_last, next_sck_last;
	logic [7:0] pin_sync_a, pin_sync_b;
	// Every pin input passes two flops; only the second stage is read.
	always_ff @(posedge clk_in) begin
		pin_a <= '{clk: sck_in, data: serial_data_in_pin_in};
		pin_b <= pin_a;
		ss_a <= slave_select_n_in;
		ss_b <= ss_a;
		t2_a <= timer_two_in;
		t2_b <= t2_a;
	end
	logic [3:0] mode;
	logic enabled, polarity, is_master, is_slave, is_i2c, edge_sel, smp_end;
	assign mode = serial_port_control[3:0];
	assign enabled = serial_port_control[`SSP_BIT_EN];
	assign polarity = serial_port_control[`SSP_BIT_CKP];
	assign edge_sel = serial_port_status[`SSP_BIT_CKE];
	assign smp_end = serial_port_status[`SSP_BIT_SMP];
	assign is_master = enabled && (mode <= `SSP_MODE_MT2); // [RULE_08]
	assign is_slave = enabled && (mode == `SSP_MODE_SSS || mode == `SSP_MODE_SNS); // [RULE_09]
	assign is_i2c = enabled && (mode == `SSP_MODE_I7 || mode == `SSP_MODE_I10 ||
		mode == `SSP_MODE_IFM || mode == `SSP_MODE_I7SP || mode == `SSP_MODE_I10SP); // [RULE_10]
	logic slave_held;
	assign slave_held = (mode == `SSP_MODE_SSS) && ss_b; // [RULE_13]
	logic buf_wr, buf_rd;
	assign buf_wr = wr_in && addr_in == `SSP_OFS_BUFFER;
	assign buf_rd = rd_in && addr_in == `SSP_OFS_BUFFER;
	// Master bit-clock tick: divider for modes 0-2, every other timer edge for mode 3.
	logic tick;
	logic [7:0] div_limit;
	always_comb begin
		case (mode)
			`SSP_MODE_M16: div_limit = `SSP_DIV_16;
			`SSP_MODE_M64: div_limit = `SSP_DIV_64;
			default: div_limit = `SSP_DIV_4;
		endcase
		tick = 1'b0;
		next_div = div_count;
		next_t2_last = t2_b;
		if (mode == `SSP_MODE_MT2) begin
			tick = t2_b && !t2_last; // [RULE_08]
		end else if (div_count >= div_limit) begin
			tick = 1'b1;
			next_div = 8'h00;
		end else begin
			next_div = div_count + 8'h01;
		end
		if (state == SSP_IDLE) begin
			next_div = 8'h00;
		end
	end
	// Slave clock edges, in the polarity-normalised sense: lead leaves idle, trail returns.
	logic sck_norm, sck_norm_last, slave_lead, slave_trail, out_on_lead;
	assign sck_norm = pin_b.clk ^ polarity;
	assign sck_norm_last = sck_last ^ polarity;
	assign slave_lead = sck_norm && !sck_norm_last;
	assign slave_trail = !sck_norm && sck_norm_last;
	// In slave mode edge select 1 drives data on the edge leaving idle: rising for idle low, falling for
	// idle high. [RULE_20]
	assign out_on_lead = edge_sel;
	// The pin round trip (registered clock out, two sync flops in) is longer than half a bit
	// at the fastest rate, so there the middle sample moves to the trailing tick. [RULE_21]
	logic sample_lead;
	assign sample_lead = !smp_end && (mode != `SSP_MODE_M4);
	always_comb begin
		next_control = serial_port_control;
		next_status = serial_port_status;
		next_buffer = serial_buffer;
		next_address = slave_address_register;
		next_shift = shift_register;
		next_count = bit_count;
		next_state = state;
		next_sclk = sclk;
		next_sdo = serial_data_out_pin;
		next_rdata = 8'h00;
		next_sin_last = pin_b.data;
		next_sck_last = pin_b.clk;
		if (rd_in) begin
			case (addr_in)
				`SSP_OFS_BUFFER: next_rdata = serial_buffer;
				`SSP_OFS_CONTROL: next_rdata = serial_port_control;
				`SSP_OFS_STATUS: next_rdata = serial_port_status;
				`SSP_OFS_ADDRESS: next_rdata = slave_address_register;
				default: next_rdata = 8'h00;
			endcase
		end
		if (buf_rd) begin
			next_status[`SSP_BIT_BF] = 1'b0; // [RULE_22]
		end
		if (wr_in) begin
			case (addr_in)
				`SSP_OFS_CONTROL: next_control = wdata_in;
				`SSP_OFS_STATUS: next_status[7:6] = wdata_in[7:6];
				`SSP_OFS_ADDRESS: next_address = wdata_in;
				default: ;
			endcase
		end
		if (buf_wr) begin
			next_buffer = wdata_in;
			if (state != SSP_IDLE) begin
				next_control[`SSP_BIT_WRITE_COLLISION_FLAG] = 1'b1; // [RULE_01]
			end else if (is_master || is_slave) begin
				// The buffer feeds the hidden shifter; no other path reaches it. [RULE_18]
				next_shift = wdata_in;
				next_count = 4'h0;
				next_state = is_master ? SSP_LEAD : SSP_TRAIL;
				next_sdo = wdata_in[7];
			end
		end
		if (is_master && tick && state != SSP_IDLE) begin
			if (state == SSP_LEAD) begin
				next_sclk = !polarity;
				next_state = SSP_TRAIL;
				if (sample_lead) begin
					next_shift = {shift_register[6:0], pin_b.data}; // [RULE_21]
				end
			end else begin
				next_sclk = polarity; // [RULE_06]
				if (!sample_lead) begin
					next_shift = {shift_register[6:0], pin_b.data}; // [RULE_21]
				end
				next_count = bit_count + 4'h1; // [RULE_11]
				if (bit_count + 4'h1 == `SSP_BITS) begin
					next_state = SSP_IDLE;
					next_buffer = sample_lead ? shift_register : {shift_register[6:0], pin_b.data};
					next_status[`SSP_BIT_BF] = 1'b1; // [RULE_03] [RULE_22]
				end else begin
					next_state = SSP_LEAD;
					next_sdo = sample_lead ? shift_register[7] : shift_register[6];
				end
			end
		end
		if (is_slave && !slave_held) begin
			if ((out_on_lead ? slave_trail : slave_lead)) begin
				next_shift = {shift_register[6:0], pin_b.data}; // [RULE_11]
				next_count = bit_count + 4'h1;
				if (bit_count + 4'h1 == `SSP_BITS) begin
					next_count = 4'h0;
					next_state = SSP_IDLE;
					if (serial_port_status[`SSP_BIT_BF] && !buf_rd) begin
						next_control[`SSP_BIT_OVF] = 1'b1; // [RULE_02]
					end else begin
						next_buffer = {shift_register[6:0], pin_b.data};
						next_status[`SSP_BIT_BF] = 1'b1; // [RULE_22]
					end
				end
			end else if ((out_on_lead ? slave_lead : slave_trail) && bit_count != 4'h0) begin
				next_sdo = shift_register[7];
			end
		end
		if (slave_held) begin
			next_count = 4'h0; // [RULE_13]
			next_state = SSP_IDLE;
		end
		// Start: data falls while clock high. Stop: data rises while clock high. [RULE_16]
		if (is_i2c && pin_b.clk && sck_last) begin
			if (!pin_b.data && sin_last) begin
				next_status[`SSP_BIT_START] = 1'b1;
				next_status[`SSP_BIT_STOP] = 1'b0;
			end else if (pin_b.data && !sin_last) begin
				next_status[`SSP_BIT_STOP] = 1'b1;
				next_status[`SSP_BIT_START] = 1'b0;
			end
		end
		if (!enabled) begin
			next_state = SSP_IDLE; // [RULE_12]
			next_count = 4'h0;
			next_sclk = polarity;
			next_status[`SSP_BIT_START] = 1'b0;
			next_status[`SSP_BIT_STOP] = 1'b0;
		end else if (state == SSP_IDLE) begin
			next_sclk = polarity; // [RULE_06]
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			serial_port_control <= `SSP_CTRL_RESET; // [RULE_19]
			serial_port_status <= `SSP_STAT_RESET;
			slave_address_register <= 8'h00;
			shift_register <= 8'h00;
			bit_count <= 4'h0;
			div_count <= 8'h00;
			state <= SSP_IDLE;
			sclk <= 1'b0;
			serial_data_out_pin <= 1'b0;
			rdata <= 8'h00;
			t2_last <= 1'b0;
			sin_last <= 1'b1;
			sck_last <= 1'b1;
		end else begin
			serial_port_control <= next_control;
			serial_port_status <= next_status;
			slave_address_register <= next_address;
			shift_register <= next_shift;
			bit_count <= next_count;
			div_count <= next_div;
			state <= next_state;
			sclk <= next_sclk;
			serial_data_out_pin <= next_sdo;
			rdata <= next_rdata;
			t2_last <= next_t2_last;
			sin_last <= next_sin_last;
			sck_last <= next_sck_last;
		end
	end
	// The buffer keeps its content through reset, as software may still want it. [RULE_19]
	always_ff @(posedge clk_in) begin
		serial_buffer <= next_buffer;
	end
	// Pin drivers, registered so each output comes straight from a flop.
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sck_out <= 1'b0;
			sck_oe_out <= 1'b0;
			serial_data_out_pin_out <= 1'b0;
			serial_data_out_pin_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			sck_out <= is_i2c ? 1'b0 : sclk; // [RULE_05] [RULE_17]
			sck_oe_out <= is_master || (is_i2c && !polarity); // [RULE_07] [RULE_23]
			serial_data_out_pin_out <= serial_data_out_pin;
			serial_data_out_pin_oe_out <= (is_master || (is_slave && !slave_held)); // [RULE_05]
			sda_oe_out <= 1'b0; // [RULE_17]
		end
	end
	assign rdata_out = rdata;
	chk_write_collision_flag_set: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_01]
		buf_wr && state != SSP_IDLE |=> serial_port_control[`SSP_BIT_WRITE_COLLISION_FLAG])
		else $error("collision not flagged");
	chk_master_no_ovf: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_03]
		is_master && !(wr_in && addr_in == `SSP_OFS_CONTROL) && !serial_port_control[`SSP_BIT_OVF]
		|=> !serial_port_control[`SSP_BIT_OVF])
		else $error("overflow set as master");
	chk_idle_clock: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_06]
		is_master && state == SSP_IDLE && $stable(serial_port_control) ##1
		$stable(serial_port_control) |=> sck_out == polarity)
		else $error("idle clock level wrong");
	chk_stretch: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_07]
		is_i2c && !polarity |=> sck_oe_out && !sck_out)
		else $error("clock not held low");
	chk_disabled_pins: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_05]
		!enabled |=> !sck_oe_out && !serial_data_out_pin_oe_out)
		else $error("pins driven while disabled");
	chk_reserved_mode: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_23]
		enabled && !is_master && !is_slave && !is_i2c |=> !sck_oe_out && !sda_oe_out)
		else $error("reserved mode drives pins");
	chk_master_len: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_11]
		is_master && mode == `SSP_MODE_M4 && buf_wr && state == SSP_IDLE
		|-> ##[30:40] state == SSP_IDLE)
		else $error("master transfer length wrong");
	chk_ss_reset: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_13]
		slave_held && enabled |=> bit_count == 4'h0)
		else $error("select high did not reset");
	chk_bf_read: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_22]
		buf_rd && state == SSP_IDLE && !is_slave |=> !serial_port_status[`SSP_BIT_BF])
		else $error("buffer full not cleared");
endmodule : ssp_port

// File: ssp_spi_peer.sv
// Behavioural SPI peripheral that answers each byte, MSB first.
// Assumes clock idle low, data taken on the rising clock edge.
`timescale 1ns/1ps
module ssp_spi_peer (
	input wire logic sck_in,
	input wire logic mosi_in,
	output logic miso_out
);
	logic [7:0] tx;
	logic [7:0] rx;
	initial begin
		tx = 8'h00;
		rx = 8'h00;
	end
	task automatic load(input logic [7:0] value);
		tx = value;
	endtask : load
	always @(posedge sck_in) begin
		rx <= {rx[6:0], mosi_in};
	end
	// Inverted bits are shifted in so a stale level never looks like valid data.
	always @(negedge sck_in) begin
		tx <= {tx[6:0], ~tx[0]};
	end
	assign miso_out = tx[7];
endmodule : ssp_spi_peer

// File: test_sync_serial_port_spi_i2c.sv
// Self-checking bench for the serial port: registers, master, slave and I2C pins.
// Assumes the register map of the defines header and a peer on the SPI pins.
`timescale 1ns/1ps
`include "ssp_defines.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_sync_serial_port_spi_i2c;
	logic clk, rstn, wr, rd, tb_sck, ss_n, sck_out, sck_oe, serial_data_out_pin, sdo_oe, sda_oe, miso, sck_w;
	logic [7:0] addr, wdata, rdata, rd_val;
	logic [3:0] tcnt;
	int err_count, num_checks;
	time sck_prev, sck_period;
	// The clock pin level resolves from the port's enable, else the bench drives it.
	assign sck_w = sck_oe ? sck_out : tb_sck;
	ssp_port i_ssp_port (.clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .timer_two_in(tcnt[3]), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe_out(sck_oe), .serial_data_in_pin_in(miso),
		.serial_data_out_pin_out(serial_data_out_pin), .serial_data_out_pin_oe_out(sdo_oe),
		.sda_oe_out(sda_oe), .slave_select_n_in(ss_n));
	ssp_spi_peer i_ssp_spi_peer (.sck_in(sck_w), .mosi_in(serial_data_out_pin), .miso_out(miso));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) tcnt <= tcnt + 4'h1;
	always @(posedge sck_out) begin
		sck_period = $time - sck_prev;
		sck_prev = $time;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rd_val = rdata;
	endtask : bus_rd
	// Pin outputs follow a control write two edges later.
	task automatic set_ctrl(input logic [7:0] d);
		bus_wr(`SSP_OFS_CONTROL, d);
		repeat (2) @(posedge clk);
		#1;
	endtask : set_ctrl
	task automatic wait_full();
		int n;
		for (n = 0; n < 400; n++) begin
			bus_rd(`SSP_OFS_STATUS);
			if (rd_val[`SSP_BIT_BF] === 1'b1) break;
		end
		if (n == 400) begin
			err_count++;
			end_of_test();
		end
	endtask : wait_full
	task automatic slave_byte(input logic [7:0] d);
		i_ssp_spi_peer.load(d);
		repeat (8) begin
			repeat (8) @(posedge clk);
			tb_sck <= 1'b1;
			repeat (8) @(posedge clk);
			tb_sck <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask : slave_byte
	task automatic test_regs();
		bus_rd(`SSP_OFS_CONTROL);
		`CHK(rd_val, `SSP_CTRL_RESET)
		bus_rd(`SSP_OFS_STATUS);
		`CHK(rd_val, `SSP_STAT_RESET)
		bus_wr(`SSP_OFS_STATUS, 8'hFF);
		bus_rd(`SSP_OFS_STATUS);
		`CHK(rd_val, 8'hC0)
		bus_wr(`SSP_OFS_STATUS, 8'h00);
		bus_rd(8'h50);
		`CHK(rd_val, 8'h00)
		`CHK({sck_oe, sdo_oe}, 2'b00)
		$display("register test done");
	endtask : test_regs
	task automatic test_master(input logic [3:0] mode, input time per);
		set_ctrl(8'h00);
		set_ctrl({4'h2, mode});
		`CHK({sck_oe, sck_out}, 2'b10)
		i_ssp_spi_peer.load(8'h3C);
		bus_wr(`SSP_OFS_BUFFER, 8'hA5);
		wait_full();
		`CHK(sck_period, per * 10)
		`CHK(i_ssp_spi_peer.rx, 8'hA5)
		bus_rd(`SSP_OFS_BUFFER);
		`CHK(rd_val, 8'h3C)
		bus_rd(`SSP_OFS_STATUS);
		`CHK(rd_val[`SSP_BIT_BF], 1'b0)
		bus_rd(`SSP_OFS_CONTROL);
		`CHK(rd_val, {4'h2, mode})
		$display("master mode %h done", mode);
	endtask : test_master
	task automatic test_collision();
		i_ssp_spi_peer.load(8'h96);
		bus_wr(`SSP_OFS_BUFFER, 8'h11);
		bus_wr(`SSP_OFS_BUFFER, 8'h22);
		bus_rd(`SSP_OFS_CONTROL);
		`CHK(rd_val[`SSP_BIT_WRITE_COLLISION_FLAG], 1'b1)
		wait_full();
		`CHK(i_ssp_spi_peer.rx, 8'h11)
		bus_rd(`SSP_OFS_BUFFER);
		`CHK(rd_val, 8'h96)
		bus_rd(`SSP_OFS_CONTROL);
		`CHK(rd_val[`SSP_BIT_WRITE_COLLISION_FLAG], 1'b1)
		$display("collision test done");
	endtask : test_collision
	task automatic test_slave();
		set_ctrl(8'h00);
		set_ctrl(8'h25);
		slave_byte(8'h5A);
		bus_rd(`SSP_OFS_STATUS);
		`CHK(rd_val[`SSP_BIT_BF], 1'b1)
		slave_byte(8'hC3);
		bus_rd(`SSP_OFS_CONTROL);
		`CHK(rd_val[`SSP_BIT_OVF], 1'b1)
		bus_rd(`SSP_OFS_BUFFER);
		`CHK(rd_val, 8'h5A)
		set_ctrl(8'h00);
		set_ctrl(8'h24);
		slave_byte(8'h77);
		bus_rd(`SSP_OFS_STATUS);
		`CHK(rd_val[`SSP_BIT_BF], 1'b0)
		@(posedge clk);
		ss_n <= 1'b0;
		slave_byte(8'h6E);
		bus_rd(`SSP_OFS_BUFFER);
		`CHK(rd_val, 8'h6E)
		@(posedge clk);
		ss_n <= 1'b1;
		$display("slave test done");
	endtask : test_slave
	task automatic test_pins();
		logic [3:0] codes [4] = '{4'h6, 4'h7, 4'hE, 4'hF};
		foreach (codes[i]) begin
			set_ctrl({4'h2, codes[i]});
			`CHK({sck_oe, sck_out, sda_oe}, 3'b100)
			set_ctrl({4'h3, codes[i]});
			`CHK({sck_oe, sda_oe}, 2'b00)
		end
		set_ctrl(8'h28);
		`CHK({sck_oe, sdo_oe}, 2'b00)
		set_ctrl(8'h30);
		`CHK(sck_out, 1'b1)
		set_ctrl(8'h10);
		`CHK({sck_oe, sdo_oe}, 2'b00)
		$display("pin test done");
	endtask : test_pins
	initial begin
		rstn = 1'b0;
		{wr, rd, tb_sck, addr, wdata, tcnt, err_count, num_checks} = '0;
		{sck_prev, sck_period} = '0;
		ss_n = 1'b1;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		test_regs();
		test_master(4'h0, 4);
		test_master(4'h1, 16);
		test_master(4'h2, 64);
		test_master(4'h3, 32);
		test_collision();
		test_slave();
		test_pins();
		end_of_test();
	end
endmodule : test_sync_serial_port_spi_i2c
